// file: clkctl_defs.svh
// offsets, field positions, reset values and counts of the clock control
`ifndef CLKCTL_DEFS_SVH
`define CLKCTL_DEFS_SVH

// register byte offsets on the register bus
`define CC_TRIM_OFFSET    8'h00
`define CC_DIVCTL_OFFSET  8'h04
`define CC_ASYNC_OFFSET   8'h08

// field positions in the divide control register
`define CC_UNLOCK_BIT     7
`define CC_SEL_MSB        3
`define CC_SEL_LSB        0

// field positions in the trim register
`define CC_RANGE_BIT      7
`define CC_FINE_MSB       6

// field positions in the async status register
`define CC_EXTERNAL_CLOCK_SELECT_BIT     0
`define CC_PINLVL_BIT     1

// division select codes
`define CC_SEL_DIV1       4'h0
`define CC_SEL_DIV8       4'h3
`define CC_SEL_MAX        4'h8

// unlock key and window length in clock cycles
`define CC_UNLOCK_KEY     8'h80
`define CC_UNLOCK_CYCLES  3'h4

// bus responses
`define CC_RESP_OKAY      2'h0
`define CC_RESP_SLVERR    2'h2

`endif

// file: clkctl_pkg.sv
// types shared by the clock control modules
package clkctl_pkg;

  // divider switching state
  typedef enum logic [0:0]
  {
    DIV_RUN    = 1'b0,
    DIV_SWITCH = 1'b1
  } div_state_e;

  // one-cycle enables for the four divided clock domains
  typedef struct packed
  {
    logic cpu;
    logic flash;
    logic io;
    logic conv;
  } domain_clk_s;

  // request to the divider for a new setting
  typedef struct packed
  {
    logic [3:0] sel;
    logic       load;
  } div_cmd_s;

  typedef logic [7:0] byte_t;

endpackage

// file: pin_sync3.sv
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/10ps
module pin_sync3
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // shift the pin through three flops
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // accept a new level once the last two stages agree
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      level <= 1'b0;
    else if (s2_reg == s3_reg)
      level <= s3_reg;
  end

endmodule

// file: clk_ripple_div.sv
// glitch-free power-of-two divider run from the undivided source clock
`timescale 1ns/10ps
`include "clkctl_defs.svh"
module clk_ripple_div
#(
  parameter int CNT_W = 8
)
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic [3:0]             sel_init,
  input  wire clkctl_pkg::div_cmd_s   cmd,
  output clkctl_pkg::domain_clk_s     ticks,
  output logic [3:0]                  sel_active
);
  import clkctl_pkg::*;

  div_state_e        state_reg;
  logic [3:0]        pend_sel_reg;
  logic [CNT_W-1:0]  cnt_reg;
  logic              period_end;

  // terminal count of a period: factor minus one, reserved codes clamp
  function automatic logic [CNT_W-1:0] term_count(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > `CC_SEL_MAX) ? `CC_SEL_MAX : sel;
    term_count = CNT_W'((32'h0000_0001 << s) - 32'h0000_0001);
  endfunction

  assign period_end = (cnt_reg == term_count(sel_active));

  // count state stays internal, only the enables and the active code leave the block
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt_reg <= '0;
    else if (period_end)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + CNT_W'(1);
  end

  // hold a new setting until the running period has closed
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg    <= DIV_RUN;
      pend_sel_reg <= `CC_SEL_DIV1;
      sel_active   <= sel_init;
    end
    else
    begin
      unique case (state_reg)
        DIV_RUN:
        begin
          if (cmd.load)
          begin
            state_reg    <= DIV_SWITCH;
            pend_sel_reg <= cmd.sel;
          end
        end
        DIV_SWITCH:
        begin
          if (cmd.load)
            pend_sel_reg <= cmd.sel;
          else if (period_end)
          begin
            sel_active <= pend_sel_reg;
            state_reg  <= DIV_RUN;
          end
        end
      endcase
    end
  end

  // one shared enable for every domain, issued at each period close
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ticks <= '0;
    else
      ticks <= {4{period_end}};
  end

endmodule

// file: clk_ctrl_top.sv
// clock control: divider registers, oscillator trim and timer pin select
`timescale 1ns/10ps
`include "clkctl_defs.svh"

// Summary of operation
// - external clock select lets timer input pin take a driven clock.
// - one division factor feeds CPU, flash, I/O and converter domains.
// - setting changes make no glitch nor any period shorter than either.
// - divider counts on undivided source clock; its count is not readable.
// - new rate starts once the running old period closes, within one old period.
// - unlock bit 7 sets only when all other divider bits are zero.
// - hardware clears unlock four cycles after set or on field write.
// - rewriting unlock inside its window neither restarts nor clears it.
// - field bits 3..0 give factor two to the code, up to 256.
// - reset loads field 0000, or 0011 when divide-by-eight fuse set.
// - field accepts any written value whatever the fuse state.
// - reset loads factory calibration byte into oscillator trim register.
// - trim bit 7 picks lower or upper overlapping frequency range.
// - lower seven trim bits tune frequency upward within the range.
module clk_ctrl_top
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic                    CLK,
  input  wire logic                    RST_N,
  input  wire logic                    DIVIDE_BY_EIGHT_FUSE,
  input  wire clkctl_pkg::byte_t       FACTORY_TRIM,
  input  wire logic [ADDR_W-1:0]       AWADDR,
  input  wire logic                    AWVALID,
  output logic                         AWREADY,
  input  wire logic [31:0]             WDATA,
  input  wire logic [3:0]              WSTRB,
  input  wire logic                    WVALID,
  output logic                         WREADY,
  output logic [1:0]                   BRESP,
  output logic                         BVALID,
  input  wire logic                    BREADY,
  input  wire logic [ADDR_W-1:0]       ARADDR,
  input  wire logic                    ARVALID,
  output logic                         ARREADY,
  output logic [31:0]                  RDATA,
  output logic [1:0]                   RRESP,
  output logic                         RVALID,
  input  wire logic                    RREADY,
  input  wire logic                    TIMER_OSC_IN,
  output logic                         TIMER_OSC_AMP_EN,
  output logic                         TIMER_CLK_EDGE,
  output logic                         TRIM_RANGE_BIT,
  output logic [6:0]                   TRIM_FINE_FIELD,
  output logic [3:0]                   DIVIDE_ACTIVE,
  output clkctl_pkg::domain_clk_s      DOMAIN_CLK_EN
);
  import clkctl_pkg::*;

  // write channel holding registers
  logic              aw_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic              w_held_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              wr_fire;
  logic              wr_hit;

  // read channel
  logic [31:0]       rd_word;
  logic              rd_hit;

  // software-visible state
  byte_t             trim_reg;
  logic [3:0]        sel_reg;
  logic              unlock_reg;
  logic [2:0]        unlock_cnt_reg;
  logic              ext_sel_reg;

  // decoded write actions on the divider register
  logic              div_wr;
  logic              unlock_key;
  logic              sel_write;
  div_cmd_s          div_cmd;

  // timer pin
  logic              pin_level;
  logic              pin_level_d_reg;

  // byte address of a register matches the given offset
  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [7:0]        off);
    addr_is = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
  endfunction

  // one of the three mapped registers
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = addr_is(a, `CC_TRIM_OFFSET)
                | addr_is(a, `CC_DIVCTL_OFFSET)
                | addr_is(a, `CC_ASYNC_OFFSET);
  endfunction

  // address and data are taken in either order, one write at a time
  assign AWREADY = !aw_held_reg && !BVALID;
  assign WREADY  = !w_held_reg && !BVALID;
  assign wr_fire = aw_held_reg && w_held_reg && !BVALID;
  assign wr_hit  = wr_fire && addr_mapped(aw_addr_reg);

  // capture the write address
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end
    else if (AWVALID && AWREADY)
    begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= AWADDR;
    end
    else if (wr_fire)
      aw_held_reg <= 1'b0;
  end

  // capture the write data and strobes
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end
    else if (WVALID && WREADY)
    begin
      w_held_reg <= 1'b1;
      w_data_reg <= WDATA;
      w_strb_reg <= WSTRB;
    end
    else if (wr_fire)
      w_held_reg <= 1'b0;
  end

  // write response one cycle after both halves are held
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      BVALID <= 1'b0;
      BRESP  <= `CC_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      BVALID <= 1'b1;
      BRESP  <= wr_hit ? `CC_RESP_OKAY : `CC_RESP_SLVERR;
    end
    else if (BREADY)
      BVALID <= 1'b0;
  end

  // register contents lie in byte lane 0
  assign div_wr     = wr_hit && w_strb_reg[0]
                    && addr_is(aw_addr_reg, `CC_DIVCTL_OFFSET);
  assign unlock_key = (w_data_reg[7:0] == `CC_UNLOCK_KEY);
  assign sel_write  = div_wr && unlock_reg
                    && !w_data_reg[`CC_UNLOCK_BIT];

  // oscillator trim, factory byte at reset, free to rewrite later
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      trim_reg <= FACTORY_TRIM;
    else if (wr_hit && w_strb_reg[0]
             && addr_is(aw_addr_reg, `CC_TRIM_OFFSET))
      trim_reg <= w_data_reg[7:0];
  end

  // split range and fine fields toward the oscillator
  assign TRIM_RANGE_BIT  = trim_reg[`CC_RANGE_BIT];
  assign TRIM_FINE_FIELD = trim_reg[`CC_FINE_MSB:0];

  // unlock bit and its fixed window
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      unlock_reg     <= 1'b0;
      unlock_cnt_reg <= '0;
    end
    else if (sel_write)
    begin
      unlock_reg     <= 1'b0;
      unlock_cnt_reg <= '0;
    end
    else if (unlock_reg)
    begin
      // a second key write inside the window changes nothing
      if (unlock_cnt_reg == `CC_UNLOCK_CYCLES - 3'h1)
      begin
        unlock_reg     <= 1'b0;
        unlock_cnt_reg <= '0;
      end
      else
        unlock_cnt_reg <= unlock_cnt_reg + 3'h1;
    end
    else if (div_wr && unlock_key)
    begin
      unlock_reg     <= 1'b1;
      unlock_cnt_reg <= '0;
    end
  end

  // division field, taken from any value once unlocked
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      sel_reg <= DIVIDE_BY_EIGHT_FUSE ? `CC_SEL_DIV8
                                      : `CC_SEL_DIV1;
    else if (sel_write)
      sel_reg <= w_data_reg[`CC_SEL_MSB:`CC_SEL_LSB];
  end

  assign div_cmd.sel  = w_data_reg[`CC_SEL_MSB:`CC_SEL_LSB];
  assign div_cmd.load = sel_write;

  // divider from the undivided source clock
  clk_ripple_div
  #(
    .CNT_W (8)
  )
  u_div
  (
    .clk        (CLK),
    .rst_n      (RST_N),
    .sel_init   (DIVIDE_BY_EIGHT_FUSE ? `CC_SEL_DIV8 : `CC_SEL_DIV1),
    .cmd        (div_cmd),
    .ticks      (DOMAIN_CLK_EN),
    .sel_active (DIVIDE_ACTIVE)
  );

  // external clock select in the async status register
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      ext_sel_reg <= 1'b0;
    else if (wr_hit && w_strb_reg[0]
             && addr_is(aw_addr_reg, `CC_ASYNC_OFFSET))
      ext_sel_reg <= w_data_reg[`CC_EXTERNAL_CLOCK_SELECT_BIT];
  end

  // timer input pin into the clock domain
  pin_sync3 u_pin_sync
  (
    .clk   (CLK),
    .rst_n (RST_N),
    .pin   (TIMER_OSC_IN),
    .level (pin_level)
  );

  // rising edge of a driven clock on the timer pin
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      pin_level_d_reg <= 1'b0;
      TIMER_CLK_EDGE  <= 1'b0;
    end
    else
    begin
      pin_level_d_reg <= pin_level;
      TIMER_CLK_EDGE  <= ext_sel_reg
                       && pin_level && !pin_level_d_reg;
    end
  end

  // crystal amplifier runs only when no driven clock is chosen
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      TIMER_OSC_AMP_EN <= 1'b1;
    else
      TIMER_OSC_AMP_EN <= !ext_sel_reg;
  end

  // read word; reserved bits and unused lanes are zero
  always_comb
  begin
    rd_word = '0;
    rd_hit  = 1'b1;
    if (addr_is(ARADDR, `CC_TRIM_OFFSET))
      rd_word[7:0] = trim_reg;
    else if (addr_is(ARADDR, `CC_DIVCTL_OFFSET))
    begin
      rd_word[`CC_UNLOCK_BIT]           = unlock_reg;
      rd_word[`CC_SEL_MSB:`CC_SEL_LSB] = sel_reg;
    end
    else if (addr_is(ARADDR, `CC_ASYNC_OFFSET))
    begin
      rd_word[`CC_EXTERNAL_CLOCK_SELECT_BIT] = ext_sel_reg;
      rd_word[`CC_PINLVL_BIT] = pin_level;
    end
    else
      rd_hit = 1'b0;
  end

  assign ARREADY = !RVALID;

  // read answer one cycle after the address is taken
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      RVALID <= 1'b0;
      RDATA  <= '0;
      RRESP  <= `CC_RESP_OKAY;
    end
    else if (ARVALID && ARREADY)
    begin
      RVALID <= 1'b1;
      RDATA  <= rd_word;
      RRESP  <= rd_hit ? `CC_RESP_OKAY : `CC_RESP_SLVERR;
    end
    else if (RREADY)
      RVALID <= 1'b0;
  end

endmodule

// file: clk_ctrl_assertions.sv
// concurrent checks on the clock control ports
`timescale 1ns/10ps
module clk_ctrl_assertions
(
  input wire logic                    CLK,
  input wire logic                    RST_N,
  input wire logic                    DIVIDE_BY_EIGHT_FUSE,
  input wire logic [1:0]              BRESP,
  input wire logic                    BVALID,
  input wire logic                    BREADY,
  input wire logic                    ARVALID,
  input wire logic                    ARREADY,
  input wire logic [31:0]             RDATA,
  input wire logic                    RVALID,
  input wire logic                    RREADY,
  input wire logic                    TIMER_OSC_AMP_EN,
  input wire logic                    TIMER_CLK_EDGE,
  input wire logic [3:0]              DIVIDE_ACTIVE,
  input wire clkctl_pkg::domain_clk_s DOMAIN_CLK_EN
);
  import clkctl_pkg::*;
  logic [9:0] gap_reg;
  logic [3:0] lo_reg;
  logic [3:0] cl;
  logic [3:0] lo;
  logic       seen_reg;

  // active code, reserved codes clamped, and lowest code this period
  assign cl = (DIVIDE_ACTIVE > 4'h8) ? 4'h8 : DIVIDE_ACTIVE;
  assign lo = (cl < lo_reg) ? cl : lo_reg;

  // cycles since the last tick
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      gap_reg <= 10'h000;
      lo_reg <= 4'h8;
      seen_reg <= 1'b0;
    end
    else if (DOMAIN_CLK_EN.cpu)
    begin
      gap_reg <= 10'h001;
      lo_reg <= cl;
      seen_reg <= 1'b1;
    end
    else
    begin
      gap_reg <= gap_reg + 10'h001;
      lo_reg <= lo;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  domains_equal_a: assert property (
    (&DOMAIN_CLK_EN) == (|DOMAIN_CLK_EN))
    else $error("domain enables differ");
  tick_spacing_a: assert property (
    DOMAIN_CLK_EN.cpu && seen_reg |-> gap_reg >= (10'h001 << lo))
    else $error("tick period too short");
  fuse_load_a: assert property (disable iff (1'b0)
    !RST_N |=> DIVIDE_ACTIVE == ($past(DIVIDE_BY_EIGHT_FUSE) ? 4'h3 : 4'h0))
    else $error("divide code not loaded from fuse");
  resp_hold_a: assert property (
    BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  read_hold_a: assert property (
    RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  read_answer_a: assert property (
    ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  edge_ext_a: assert property (
    TIMER_CLK_EDGE |-> !TIMER_OSC_AMP_EN)
    else $error("pin edge while crystal selected");
  edge_pulse_a: assert property (
    TIMER_CLK_EDGE |=> !TIMER_CLK_EDGE)
    else $error("pin edge pulse too long");

  cover property (DOMAIN_CLK_EN.cpu && DIVIDE_ACTIVE == 4'h8);
  cover property (TIMER_CLK_EDGE);
  cover property (BVALID && BRESP == 2'h2);
endmodule

bind clk_ctrl_top clk_ctrl_assertions chk_i
(
  .CLK, .RST_N, .DIVIDE_BY_EIGHT_FUSE, .BRESP, .BVALID, .BREADY,
  .ARVALID, .ARREADY, .RDATA, .RVALID, .RREADY, .TIMER_OSC_AMP_EN,
  .TIMER_CLK_EDGE, .DIVIDE_ACTIVE, .DOMAIN_CLK_EN
);

// file: clk_ctrl_top_tb.sv
// self-checking bench for the clock control block
`timescale 1ns/10ps
module clk_ctrl_top_tb;
  import clkctl_pkg::*;
  logic        CLK, RST_N, DIVIDE_BY_EIGHT_FUSE, TIMER_OSC_IN;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY, TIMER_OSC_AMP_EN;
  logic        TIMER_CLK_EDGE, TRIM_RANGE_BIT, aw, w, ar, b;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, d;
  logic [1:0]  BRESP, RRESP, r;
  logic [6:0]  TRIM_FINE_FIELD;
  logic [7:0]  FACTORY_TRIM;
  logic [3:0]  DIVIDE_ACTIVE;
  domain_clk_s DOMAIN_CLK_EN;
  int          failures, n_tests, edges, k, g;

  clk_ctrl_top #(.ADDR_W(8)) DUT
  (
    .CLK, .RST_N, .DIVIDE_BY_EIGHT_FUSE, .FACTORY_TRIM, .AWADDR,
    .AWVALID, .AWREADY, .WDATA, .WSTRB(4'hF), .WVALID, .WREADY, .BRESP,
    .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP,
    .RVALID, .RREADY, .TIMER_OSC_IN, .TIMER_OSC_AMP_EN, .TIMER_CLK_EDGE,
    .TRIM_RANGE_BIT, .TRIM_FINE_FIELD, .DIVIDE_ACTIVE, .DOMAIN_CLK_EN
  );

  // clock and pin edge pulse counter
  always #4 CLK = ~CLK;
  always @(posedge CLK) if (TIMER_CLK_EDGE === 1'b1) edges++;

  // compare and count
  task chk(input logic [31:0] gv, input logic [31:0] ev);
    n_tests++;
    if (gv !== ev)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, gv, ev);
    end
  endtask

  // bus write, response ready raised after st cycles
  task wr(input logic [7:0] a, input logic [31:0] v, input int st = 1);
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    k = 0;
    do
    begin
      @(negedge CLK);
      aw = AWREADY;
      w = WREADY;
      b = BVALID & BREADY;
      r = BRESP;
      @(posedge CLK);
      if (aw) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
      k++;
      if (k == st) BREADY <= 1'b1;
    end
    while (!b);
    BREADY <= 1'b0;
  endtask

  // bus read, data ready raised after st cycles
  task rd(input logic [7:0] a, input int st = 1);
    ARADDR <= a;
    ARVALID <= 1'b1;
    k = 0;
    do
    begin
      @(negedge CLK);
      ar = ARREADY;
      b = RVALID & RREADY;
      d = RDATA;
      r = RRESP;
      @(posedge CLK);
      if (ar) ARVALID <= 1'b0;
      k++;
      if (k == st) RREADY <= 1'b1;
    end
    while (!b);
    RREADY <= 1'b0;
  endtask

  // read and compare, and the unlock key write
  task rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask
  task key;
    wr(8'h04, 32'h0000_0080);
  endtask

  // reset with a given fuse level and factory trim byte
  task t_reset(input logic f);
    RST_N <= 1'b0;
    DIVIDE_BY_EIGHT_FUSE <= f;
    FACTORY_TRIM <= f ? 8'h5A : 8'hA5;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    chk(DIVIDE_ACTIVE, f ? 3 : 0);
    rc(8'h04, f ? 3 : 0);
    rc(8'h00, f ? 8'h5A : 8'hA5);
    chk({TRIM_RANGE_BIT, TRIM_FINE_FIELD}, f ? 8'h5A : 8'hA5);
    $display("reset test done");
  endtask

  // trim values on both sides of the range boundary
  task t_trim;
    logic [7:0] v;
    for (int i = 0; i < 2; i++)
    begin
      v = i ? 8'h80 : 8'h7F;
      wr(8'h00, v);
      chk({TRIM_RANGE_BIT, TRIM_FINE_FIELD}, v);
      rc(8'h00, v);
    end
    $display("trim test done");
  endtask

  // unlock window: set, last open cycle, time-out, bad key, rewrite,
  // field write after the window, field write inside it
  task t_unlock;
    key;
    rc(8'h04, 8'h80);
    rc(8'h04, 8'h80);
    rc(8'h04, 8'h00);
    wr(8'h04, 32'h0000_0081);
    rc(8'h04, 8'h00);
    key;
    key;
    rc(8'h04, 8'h00);
    wr(8'h04, 32'h0000_0005);
    rc(8'h04, 8'h00);
    key;
    wr(8'h04, 32'h0000_0071);
    rc(8'h04, 8'h01);
    $display("unlock test done");
  endtask

  // every code incl. one reserved; tick period measured
  task t_div;
    for (int c = 0; c < 10; c++)
    begin
      key;
      wr(8'h04, c);
      rc(8'h04, c);
      repeat (800) @(posedge CLK);
      chk(DIVIDE_ACTIVE, c);
      do @(negedge CLK); while (DOMAIN_CLK_EN.cpu !== 1'b1);
      g = 0;
      do
      begin
        @(negedge CLK);
        g++;
      end
      while (DOMAIN_CLK_EN.cpu !== 1'b1);
      chk(g, 1 << (c > 8 ? 8 : c));
      chk(DOMAIN_CLK_EN, 4'hF);
      @(posedge CLK);
    end
    $display("divider test done");
  endtask

  // timer pin with external clock selected, then crystal
  task t_ext;
    for (int s = 1; s >= 0; s--)
    begin
      wr(8'h08, s);
      @(posedge CLK);
      chk(TIMER_OSC_AMP_EN, !s);
      edges = 0;
      repeat (3)
      begin
        TIMER_OSC_IN <= 1'b1;
        repeat (10) @(posedge CLK);
        rc(8'h08, s | 2);
        TIMER_OSC_IN <= 1'b0;
        repeat (10) @(posedge CLK);
      end
      chk(edges, 3 * s);
    end
    $display("timer pin test done");
  endtask

  // unmapped address with stalled responses
  task t_bus;
    wr(8'h0C, 32'h0000_00FF, 3);
    chk(r, 2'h2);
    rd(8'h0C, 3);
    chk(r, 2'h2);
    chk(d, 0);
    rc(8'h00, 8'h5A);
    chk(r, 2'h0);
    $display("bus test done");
  endtask

  // verdict and end of run
  task end_sim;
    $display("compares %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // main sequence
  initial
  begin
    CLK = 1'b0;
    RST_N = 1'b0;
    DIVIDE_BY_EIGHT_FUSE = 1'b1;
    TIMER_OSC_IN = 1'b0;
    AWVALID = 1'b0;
    WVALID = 1'b0;
    BREADY = 1'b0;
    ARVALID = 1'b0;
    RREADY = 1'b0;
    AWADDR = 8'h00;
    ARADDR = 8'h00;
    WDATA = 32'h0000_0000;
    t_reset(1'b1);
    t_reset(1'b0);
    t_trim;
    t_unlock;
    t_reset(1'b1);
    t_div;
    t_ext;
    t_bus;
    end_sim;
  end

  // watchdog against a hung handshake
  initial
  begin
    #400000;
    failures++;
    end_sim;
  end
endmodule
